// File: inc/ocs_pkg.sv
// Package with constants and types for the output channel configuration block
package ocs_pkg;
	localparam int CHAN_NUM = 4;
	localparam int REF_NUM  = 7;
	localparam int CLK_NUM  = 8;
	localparam int DIV_W    = 8;
	localparam int DLY_W    = 8;
	localparam int REF_DLY_W = 3;
	localparam int CNT_W    = 8;
	// Owning channel per sysref-capable output: A0 A1 A2 B0 B1 C D
	localparam logic [13:0] REF_CHAN_MAP = {2'h3, 2'h2, 2'h1, 2'h1, 2'h0, 2'h0, 2'h0};
	// Owning channel per clock output: A0 A1 B0 B1 C D E0 E1 (E is index 4)
	localparam logic [23:0] CLK_CHAN_MAP = {3'h4, 3'h4, 3'h3, 3'h2, 3'h1, 3'h1, 3'h0, 3'h0};
	localparam logic        SEL_CLOCK  = 1'h0;
	localparam logic        SEL_SYSREF = 1'h1;
	localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
	localparam logic [CNT_W-1:0] CNT_ONE  = 8'h01;
	typedef enum logic [2:0] {
		OCS_IDLE = 3'h1,
		OCS_RUN  = 3'h2,
		OCS_DONE = 3'h4
	} ocs_state_t;
endpackage : ocs_pkg

// File: logic/ocs_edge_cnt.sv
// Counter of pulse edges on the divided sysref rate
`timescale 1ns/100ps
module ocs_edge_cnt
	import ocs_pkg::*;
(
	input  wire logic             clk_in,
	input  wire logic             rst_b_in,
	input  wire logic             load_in,
	input  wire logic [CNT_W-1:0] count_in,
	input  wire logic             tick_in,
	output logic                  last_out
);
	logic [CNT_W-1:0] left_ff;
	logic [CNT_W-1:0] nxt_left;
	assign nxt_left = load_in ? count_in :
		((tick_in && left_ff != CNT_ZERO) ? left_ff - CNT_ONE : left_ff);
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			left_ff  <= CNT_ZERO;
			last_out <= 1'h0;
		end else begin
			left_ff  <= nxt_left;
			// Registered so the main block sees a clean terminal flag
			last_out <= !load_in && tick_in && left_ff == CNT_ONE;
		end
	end
endmodule : ocs_edge_cnt

// File: logic/ocs_top.sv
// Output channel configuration with sysref gating per output
// Operation
// - Channels A-D: clocks plus sysref-capable outputs
// - Each sysref-capable output selects sysref or clock
// - Channel E: two clocks, no sysref
// - Sysref outputs switched by channel logic
// - Clock-duty output state from own settings
// - Select picks channel or global sysref divider
// - Select picks channel or own sysref delay
// - Sysref state machine replaces output disable
// - Event turns outputs on, then off in counted mode only
// - Idle bias holds idle sysref-duty output at midpoint
// - Counted mode emits 1-255 pulses then stops
`timescale 1ns/100ps
module ocs_top
	import ocs_pkg::*;
(
	input  wire logic                     clk_in,
	input  wire logic                     rst_b_in,
	input  wire logic [REF_NUM-1:0]       output_function_select_in,
	input  wire logic [REF_NUM-1:0]       ref_enable_in,
	input  wire logic [REF_NUM-1:0]       ref_power_down_in,
	input  wire logic [REF_NUM-1:0]       idle_line_bias_in,
	input  wire logic [CLK_NUM-1:0]       clk_enable_in,
	input  wire logic [CLK_NUM-1:0]       clk_power_down_in,
	input  wire logic [CHAN_NUM:0]        chan_power_down_in,
	input  wire logic [CHAN_NUM:0]        chan_clk_in,
	input  wire logic                     sysref_rate_in,
	input  wire logic                     event_start_in,
	input  wire logic                     continuous_in,
	input  wire logic [CNT_W-1:0]         pulse_count_in,
	input  wire logic [(CHAN_NUM+1)*DIV_W-1:0] chan_div_in,
	input  wire logic [(CHAN_NUM+1)*DLY_W-1:0] chan_dly_in,
	input  wire logic [DIV_W-1:0]         sysref_div_in,
	input  wire logic [REF_NUM*REF_DLY_W-1:0] ref_dly_in,
	output logic [CLK_NUM-1:0]            channel_clock_output_out,
	output logic [CLK_NUM-1:0]            clk_on_out,
	output logic [REF_NUM-1:0]            sysref_capable_output_out,
	output logic [REF_NUM-1:0]            ref_on_out,
	output logic [REF_NUM-1:0]            ref_midbias_out,
	output logic [REF_NUM*DIV_W-1:0]      ref_div_out,
	output logic [REF_NUM*DLY_W-1:0]      ref_dly_out,
	output logic                          sysref_active_out
);
	ocs_state_t state_ff;
	ocs_state_t nxt_state;
	logic [2:0] sync_ff;
	logic       rate_prev_ff;
	logic       rate_q;
	logic       rate_tick;
	logic       cnt_last;
	logic       event_on;

	// Pulse rate is a pin from a foreign domain: three stages, second and third agree
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			sync_ff      <= 3'h0;
			rate_prev_ff <= 1'h0;
		end else begin
			sync_ff <= {sync_ff[1:0], sysref_rate_in};
			if (sync_ff[1] == sync_ff[2])
				rate_prev_ff <= sync_ff[2];
		end
	end
	assign rate_q    = (sync_ff[1] == sync_ff[2]) ? sync_ff[2] : rate_prev_ff;
	assign rate_tick = rate_q && !rate_prev_ff;

	ocs_edge_cnt u_cnt (
		.clk_in   (clk_in),
		.rst_b_in (rst_b_in),
		.load_in  (state_ff == OCS_IDLE && event_start_in),
		.count_in (pulse_count_in),
		.tick_in  (rate_tick && state_ff == OCS_RUN),
		.last_out (cnt_last)
	);

	// Zero count is refused in counted mode: range starts at one
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			OCS_IDLE: if (event_start_in && (continuous_in || pulse_count_in != CNT_ZERO))
				nxt_state = OCS_RUN;
			OCS_RUN:  if (!continuous_in && cnt_last)
				nxt_state = OCS_DONE;
			OCS_DONE: nxt_state = OCS_IDLE;
			default:  nxt_state = OCS_IDLE;
		endcase
	end
	always_ff @(posedge clk_in) begin
		if (!rst_b_in)
			state_ff <= OCS_IDLE;
		else
			state_ff <= nxt_state;
	end
	assign event_on = state_ff == OCS_RUN;

	genvar g;
	generate
		for (g = 0; g < REF_NUM; g++) begin : g_ref
			localparam int CH = int'(REF_CHAN_MAP[2*g +: 2]);
			wire sel_ref = output_function_select_in[g] == SEL_SYSREF;
			// Sysref duty: channel power-down; clock duty: per output
			wire pd  = sel_ref ? chan_power_down_in[CH] : ref_power_down_in[g];
			wire on  = !pd && (sel_ref ? event_on : ref_enable_in[g]);
			wire sig = sel_ref ? (event_on && rate_q) : chan_clk_in[CH];
			always_ff @(posedge clk_in) begin
				if (!rst_b_in) begin
					sysref_capable_output_out[g] <= 1'h0;
					ref_on_out[g]                <= 1'h0;
					ref_midbias_out[g]           <= 1'h0;
					ref_div_out[g*DIV_W +: DIV_W] <= '0;
					ref_dly_out[g*DLY_W +: DLY_W] <= '0;
				end else begin
					sysref_capable_output_out[g] <= on && sig;
					ref_on_out[g]                <= on;
					// Midpoint only while powered and idle in sysref duty
					ref_midbias_out[g] <= sel_ref && !pd && !event_on && idle_line_bias_in[g];
					ref_div_out[g*DIV_W +: DIV_W] <= sel_ref ? sysref_div_in
						: chan_div_in[CH*DIV_W +: DIV_W];
					ref_dly_out[g*DLY_W +: DLY_W] <= sel_ref
						? {{(DLY_W-REF_DLY_W){1'h0}}, ref_dly_in[g*REF_DLY_W +: REF_DLY_W]}
						: chan_dly_in[CH*DLY_W +: DLY_W];
				end
			end
		end
		// Channel E has clock outputs only; no sysref path reaches it
		for (g = 0; g < CLK_NUM; g++) begin : g_clk
			localparam int CH = int'(CLK_CHAN_MAP[3*g +: 3]);
			wire on = !clk_power_down_in[g] && !chan_power_down_in[CH] && clk_enable_in[g];
			always_ff @(posedge clk_in) begin
				if (!rst_b_in) begin
					channel_clock_output_out[g] <= 1'h0;
					clk_on_out[g]               <= 1'h0;
				end else begin
					channel_clock_output_out[g] <= on && chan_clk_in[CH];
					clk_on_out[g]               <= on;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_in) begin
		if (!rst_b_in)
			sysref_active_out <= 1'h0;
		else
			sysref_active_out <= event_on;
	end

	count_stop_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		state_ff == OCS_RUN && !continuous_in && cnt_last
		|=> state_ff == OCS_DONE ##1 state_ff == OCS_IDLE)
		else $error("counted event did not stop");
	count_hold_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		state_ff == OCS_RUN && !cnt_last |=> state_ff == OCS_RUN)
		else $error("event stopped before its count");
	// A zero count is refused without any flag, so only the state shows it
	zero_count_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		state_ff == OCS_IDLE && !continuous_in && pulse_count_in == CNT_ZERO
		|=> state_ff == OCS_IDLE)
		else $error("zero count started an event");
	start_event_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		state_ff == OCS_IDLE && event_start_in && pulse_count_in != CNT_ZERO
		|=> state_ff == OCS_RUN)
		else $error("event did not start");
	active_on_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		event_on |=> sysref_active_out)
		else $error("active flag missing during event");
	active_off_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		!event_on |=> !sysref_active_out)
		else $error("active flag outside event");
	ref_gate_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		output_function_select_in[0] && !chan_power_down_in[0]
		|=> ref_on_out[0] == $past(event_on))
		else $error("sysref output state not from sequencer");
	ref_pulse_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		output_function_select_in[0] && !chan_power_down_in[0] && event_on && rate_q
		|=> sysref_capable_output_out[0])
		else $error("sysref pulse missing");
	ref_off_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		output_function_select_in[1] && !event_on
		|=> !ref_on_out[1] && !sysref_capable_output_out[1])
		else $error("sysref output on outside event");
	ref_pd_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		!output_function_select_in[1] && ref_power_down_in[1]
		|=> !ref_on_out[1] && !sysref_capable_output_out[1])
		else $error("powered down output active");
	chan_pd_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		output_function_select_in[6] && chan_power_down_in[3]
		|=> !ref_on_out[6] && !sysref_capable_output_out[6])
		else $error("channel power-down ignored");
	clk_pd_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		clk_power_down_in[0] |=> !clk_on_out[0] && !channel_clock_output_out[0])
		else $error("powered down clock output active");
	clk_low_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		!clk_enable_in[6] |=> !channel_clock_output_out[6])
		else $error("gated clock output toggles");
	ref_low_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		!output_function_select_in[2] && !ref_enable_in[2]
		|=> !sysref_capable_output_out[2])
		else $error("gated clock duty output toggles");
	chan_e_on_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		clk_enable_in[7] && !clk_power_down_in[7] && !chan_power_down_in[4]
		|=> clk_on_out[7])
		else $error("channel E clock output not on");
	clk_copy_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		!output_function_select_in[5] && !ref_power_down_in[5] && ref_enable_in[5]
		|=> sysref_capable_output_out[5] == $past(chan_clk_in[2]))
		else $error("clock duty output not copying channel clock");
	ref_div_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		output_function_select_in[6] |=> ref_div_out[6*DIV_W +: DIV_W] == $past(sysref_div_in))
		else $error("sysref divider not selected");
	clk_div_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		!output_function_select_in[3]
		|=> ref_div_out[3*DIV_W +: DIV_W] == $past(chan_div_in[DIV_W +: DIV_W]))
		else $error("clock duty divider wrong");
	ref_dly_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		!output_function_select_in[5]
		|=> ref_dly_out[5*DLY_W +: DLY_W] == $past(chan_dly_in[2*DLY_W +: DLY_W]))
		else $error("clock duty delay wrong");
	// Own delay is only three bits wide; the upper bits must read as zero
	ref_own_dly_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		output_function_select_in[4] |=> ref_dly_out[4*DLY_W +: DLY_W] ==
		{{(DLY_W-REF_DLY_W){1'h0}}, $past(ref_dly_in[4*REF_DLY_W +: REF_DLY_W])})
		else $error("sysref own delay not selected");
	mid_bias_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		ref_midbias_out[2] |-> !ref_on_out[2])
		else $error("midpoint bias while active");
	clock_duty_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		!output_function_select_in[3] && !ref_power_down_in[3]
		|=> ref_on_out[3] == $past(ref_enable_in[3]))
		else $error("clock duty state not per output");
	cover_count_c: cover property (@(posedge clk_in) disable iff (!rst_b_in) state_ff == OCS_DONE);
	cover_cont_c: cover property (@(posedge clk_in) disable iff (!rst_b_in)
		event_on && continuous_in && rate_tick);
	cover_mid_c: cover property (@(posedge clk_in) disable iff (!rst_b_in) ref_midbias_out[0]);
	cover_zero_c: cover property (@(posedge clk_in) disable iff (!rst_b_in)
		state_ff == OCS_IDLE && event_start_in && !continuous_in && pulse_count_in == CNT_ZERO);
	cover_duty_c: cover property (@(posedge clk_in) disable iff (!rst_b_in)
		!output_function_select_in[3] && ref_on_out[3]);
endmodule : ocs_top

// File: tb/ocs_conv_model.sv
// Converter stand-in counting sysref pulses on one output line
`timescale 1ns/100ps
module ocs_conv_model (
	input  wire logic clk_in,
	input  wire logic ref_in,
	input  wire logic clr_in,
	output int        pulses_out
);
	logic ref_d;
	// Samples on its device clock, as a real converter would
	always @(posedge clk_in) begin
		ref_d <= ref_in;
		if (clr_in)
			pulses_out <= 0;
		else if (ref_in && !ref_d)
			pulses_out <= pulses_out + 1;
	end
endmodule : ocs_conv_model

// File: tb/testbench.sv
// Self-checking bench for the output channel configuration block
`timescale 1ns/100ps
module testbench;
	import ocs_pkg::*;
	logic        clk = 0, rst_b = 0, rate = 0, start = 0, cont = 0, clr = 1, act;
	logic [6:0]  fsel = 0, ren = 0, rpd = 0, bias = 0, ro, ron, rmid;
	logic [7:0]  cen = 0, cpd = 0, cko, ckon, cnt = 0, sdiv = 0;
	logic [4:0]  chpd = 0, cclk = 0;
	logic [39:0] cdiv = 0, cdly = 0;
	logic [20:0] rdly = 0;
	logic [55:0] rdivo, rdlyo;
	int          err_count = 0, total_checks = 0, cyc = 0, pulses;
	logic [63:0] exp_q[$];
	int          kind_q[$];
	always #50 clk = ~clk;
	ocs_top ocs_top_inst (.clk_in(clk), .rst_b_in(rst_b), .output_function_select_in(fsel),
		.ref_enable_in(ren), .ref_power_down_in(rpd), .idle_line_bias_in(bias),
		.clk_enable_in(cen), .clk_power_down_in(cpd), .chan_power_down_in(chpd),
		.chan_clk_in(cclk), .sysref_rate_in(rate), .event_start_in(start),
		.continuous_in(cont), .pulse_count_in(cnt), .chan_div_in(cdiv), .chan_dly_in(cdly),
		.sysref_div_in(sdiv), .ref_dly_in(rdly), .channel_clock_output_out(cko),
		.clk_on_out(ckon), .sysref_capable_output_out(ro), .ref_on_out(ron),
		.ref_midbias_out(rmid), .ref_div_out(rdivo), .ref_dly_out(rdlyo),
		.sysref_active_out(act));
	ocs_conv_model ocs_conv_model_inst (.clk_in(clk), .ref_in(ro[0]), .clr_in(clr),
		.pulses_out(pulses));
	function automatic logic [63:0] seen(int k);
		case (k)
			0: return ckon;
			1: return cko;
			2: return ron;
			3: return ro;
			4: return rmid;
			5: return rdivo;
			6: return rdlyo;
			7: return act;
			default: return pulses;
		endcase
	endfunction : seen
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t kind mismatch got %h exp %h", $time, got, exp);
		end
	endtask : check
	task automatic note(input int k, input logic [63:0] e);
		kind_q.push_back(k);
		exp_q.push_back(e);
	endtask : note
	// Outputs only move on the rising edge; the short wait lets this edge's notes land first
	always @(negedge clk) begin
		#1;
		while (kind_q.size() > 0)
			check(seen(kind_q.pop_front()), exp_q.pop_front());
	end
	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : finish_test
	always @(posedge clk) begin
		cyc++;
		if (cyc == 6000) begin
			err_count++;
			finish_test();
		end
	end
	task automatic cfg_test();
		logic [2:0]  c;
		logic [7:0]  eon, eck;
		logic [6:0]  on_e, ro_e, mid_e;
		logic [55:0] div_e, dly_e;
		{fsel, ren, rpd, bias, cen, cpd} = 44'({$urandom, $urandom});
		{chpd, cclk, sdiv, rdly} = 39'({$urandom, $urandom});
		cdiv = 40'({$urandom, $urandom});
		cdly = 40'({$urandom, $urandom});
		for (int i = 0; i < CLK_NUM; i++) begin
			c = CLK_CHAN_MAP[3*i +: 3];
			eon[i] = cen[i] & ~cpd[i] & ~chpd[c];
			eck[i] = eon[i] & cclk[c];
		end
		for (int i = 0; i < REF_NUM; i++) begin
			c = {1'h0, REF_CHAN_MAP[2*i +: 2]};
			on_e[i] = ~fsel[i] & ren[i] & ~rpd[i];
			ro_e[i] = on_e[i] & cclk[c];
			mid_e[i] = fsel[i] & bias[i] & ~chpd[c];
			div_e[8*i +: 8] = fsel[i] ? sdiv : cdiv[8*c +: 8];
			dly_e[8*i +: 8] = fsel[i] ? {5'h0, rdly[3*i +: 3]} : cdly[8*c +: 8];
		end
		repeat (3) @(negedge clk);
		note(0, eon);
		note(1, eck);
		note(2, on_e);
		note(3, ro_e);
		note(4, mid_e);
		note(5, div_e);
		note(6, dly_e);
	endtask : cfg_test
	task automatic event_test(input logic [7:0] n, input logic c);
		{fsel, chpd, bias, cnt, cont, clr, start} = {7'h7f, 5'h00, 7'h7f, n, c, 2'h1};
		@(negedge clk);
		start = 0;
		repeat (2) @(negedge clk);
		note(7, n != 0);
		note(2, n != 0 ? 7'h7f : 7'h00);
		repeat (n + 2) begin
			rate = 1;
			repeat (3) @(negedge clk);
			rate = 0;
			repeat (3) @(negedge clk);
		end
		repeat (10) @(negedge clk);
		note(8, c ? n + 2 : n);
		note(7, c);
		note(4, c ? 7'h00 : 7'h7f);
		clr = 1;
		@(negedge clk);
		$display("event test done count %0d", n);
	endtask : event_test
	initial begin
		void'($urandom(66));
		repeat (5) @(negedge clk);
		rst_b = 1;
		@(negedge clk);
		note(7, 0);
		note(2, 0);
		repeat (8) cfg_test();
		$display("config test done");
		event_test(3, 0);
		event_test(0, 0);
		event_test(1, 0);
		event_test(255, 0);
		event_test(2, 1);
		rst_b = 0;
		repeat (2) @(negedge clk);
		note(7, 0);
		note(0, 0);
		@(negedge clk);
		$display("reset test done");
		finish_test();
	end
endmodule : testbench
